/* File: control_flag_fault_gating.sv */
// Control flag registers and instruction fault gating.
// Assumes one request per cycle from the decode stage on the same clock,
// and single-cycle event pulses for task switch and machine check.
`timescale 1ns/10ps

module control_flag_fault_gating
  import fault_gating_pkg::*;
#(
  parameter bit AUX_TS_PRESENT = 1'b1
) (
  input  wire logic                           clock_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           instr_valid_i,
  input  wire fault_gating_pkg::instr_class_t instr_class_i,
  input  wire logic [1:0]                     cpl_i,
  input  wire fault_gating_pkg::cr_sel_t      cr_sel_i,
  input  wire logic [31:0]                    wr_data_i,
  input  wire logic [2:0]                     dbg_idx_i,
  input  wire logic                           task_switch_i,
  input  wire logic                           hw_check_i,
  output logic                                done_o,
  output logic                                fpu_unavailable_fault_o,
  output logic                                illegal_op_fault_o,
  output logic                                protection_fault_o,
  output logic [31:0]                         rd_data_o,
  output logic [2:0]                          dbg_index_o,
  output logic                                protected_mode_o,
  output logic                                paging_active_o,
  output logic                                root_fetch_nocache_o,
  output logic                                root_fetch_wt_o,
  output logic                                v86_ext_o,
  output logic                                prot_virq_o,
  output logic                                large_page_o,
  output logic                                wide_phys_o,
  output logic                                ext_state_vector_o,
  output logic                                tlb_flush_o,
  output logic                                keep_global_o,
  output logic                                hw_check_exc_o
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (new_v & mask) | (old_v & ~mask);
  endfunction : merge

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------

  logic [31:0] system_control_flags;
  logic [31:0] paging_root_pointer;
  logic [31:0] extension_control_flags;
  logic [31:0] next_sys;
  logic [31:0] next_root;
  logic [31:0] next_ext;
  logic        ud;
  logic        nm;
  logic        gp;
  logic        commit;
  logic        cr_write;
  logic        root_write;
  logic        next_paging;
  logic        plain_paging;

  // ------------------------------------------------------------------
  // Fault decision
  // ------------------------------------------------------------------

  fault_classifier #(
    .AUX_TS_PRESENT (AUX_TS_PRESENT)
  ) i_fault_classifier (
    .cls_i     (instr_class_i),
    .cpl_i     (cpl_i),
    .sel_i     (cr_sel_i),
    .dbg_idx_i (dbg_idx_i),
    .wr_data_i (wr_data_i),
    .sys_i     (system_control_flags),
    .ext_i     (extension_control_flags),
    .ud_o      (ud),
    .nm_o      (nm),
    .gp_o      (gp)
  );

  // A faulting request never reaches the commit term, so nothing
  // below changes state for it.
  assign commit = instr_valid_i && !ud && !nm && !gp;
  assign cr_write = commit && (instr_class_i == IC_CR_WRITE);
  assign root_write = cr_write && (cr_sel_i == SEL_ROOT);

  // ------------------------------------------------------------------
  // Next register values
  // ------------------------------------------------------------------

  always_comb begin
    next_sys = system_control_flags;
    if (cr_write && cr_sel_i == SEL_SYS) begin
      next_sys = merge(system_control_flags, wr_data_i, SYS_CTL_WMASK);
    end
    if (commit && instr_class_i == IC_CLEAR_TASK) begin
      next_sys[TASK_SW_BIT] = 1'b0;
    end
    // The switch event is applied last so it wins over a clear.
    if (task_switch_i) begin
      next_sys[TASK_SW_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_root = paging_root_pointer;
    if (root_write) begin
      next_root = merge(paging_root_pointer, wr_data_i, ROOT_PTR_WMASK);
    end
  end

  always_comb begin
    next_ext = extension_control_flags;
    if (cr_write && cr_sel_i == SEL_EXT) begin
      next_ext = merge(extension_control_flags, wr_data_i, EXT_CTL_WMASK);
    end
  end

  assign next_paging = next_sys[PROT_EN_BIT] && next_sys[PAGING_ON_BIT];

  // Root cache flags matter only without wide addressing or context ids.
  assign plain_paging = next_paging && !next_ext[WIDE_PHYS_BIT] &&
                        !next_ext[CTX_ID_BIT];

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_control_flags <= SYS_CTL_RESET;
    end else begin
      system_control_flags <= next_sys;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      paging_root_pointer <= ROOT_PTR_RESET;
    end else begin
      paging_root_pointer <= next_root;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      extension_control_flags <= EXT_CTL_RESET;
    end else begin
      extension_control_flags <= next_ext;
    end
  end

  // ------------------------------------------------------------------
  // Completion and fault reporting
  // ------------------------------------------------------------------

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o                  <= 1'b0;
      fpu_unavailable_fault_o <= 1'b0;
      illegal_op_fault_o      <= 1'b0;
      protection_fault_o      <= 1'b0;
    end else begin
      done_o                  <= commit;
      fpu_unavailable_fault_o <= instr_valid_i && nm;
      illegal_op_fault_o      <= instr_valid_i && ud;
      protection_fault_o      <= instr_valid_i && gp;
    end
  end

  // ------------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------------

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (commit && instr_class_i == IC_CR_READ) begin
      case (cr_sel_i)
        SEL_SYS: begin
          rd_data_o <= system_control_flags;
        end
        SEL_ROOT: begin
          rd_data_o <= paging_root_pointer;
        end
        SEL_EXT: begin
          rd_data_o <= extension_control_flags;
        end
        default: begin
          rd_data_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Debug register aliasing
  // ------------------------------------------------------------------

  // Untrapped references to four and five land on six and seven.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_index_o <= 3'h0;
    end else if (commit && instr_class_i == IC_DEBUG_REF) begin
      if (dbg_idx_i == DBG_REG_FOUR || dbg_idx_i == DBG_REG_FIVE) begin
        dbg_index_o <= dbg_idx_i + DBG_ALIAS_OFS;
      end else begin
        dbg_index_o <= dbg_idx_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode and paging outputs
  // ------------------------------------------------------------------

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      protected_mode_o     <= 1'b0;
      paging_active_o      <= 1'b0;
      root_fetch_nocache_o <= 1'b0;
      root_fetch_wt_o      <= 1'b0;
    end else begin
      protected_mode_o     <= next_sys[PROT_EN_BIT];
      paging_active_o      <= next_paging;
      root_fetch_nocache_o <= plain_paging && next_root[ROOT_NC_BIT];
      root_fetch_wt_o      <= plain_paging && next_root[ROOT_WT_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      v86_ext_o          <= 1'b0;
      prot_virq_o        <= 1'b0;
      large_page_o       <= 1'b0;
      wide_phys_o        <= 1'b0;
      ext_state_vector_o <= 1'b0;
    end else begin
      v86_ext_o          <= next_ext[V86_EXT_BIT];
      prot_virq_o        <= next_ext[PROT_VIRQ_BIT];
      large_page_o       <= next_ext[LARGE_PAGE_BIT];
      wide_phys_o        <= next_ext[WIDE_PHYS_BIT];
      ext_state_vector_o <= next_ext[OS_EXT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Translation flush
  // ------------------------------------------------------------------

  // Keep is sampled with the current flag; a write that changes it in
  // the same cycle as a flush affects only later flushes.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tlb_flush_o   <= 1'b0;
      keep_global_o <= 1'b0;
    end else begin
      tlb_flush_o   <= task_switch_i || root_write;
      keep_global_o <= extension_control_flags[GLOBAL_KEEP_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Machine check gating
  // ------------------------------------------------------------------

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hw_check_exc_o <= 1'b0;
    end else begin
      hw_check_exc_o <= hw_check_i && extension_control_flags[HW_CHECK_BIT];
    end
  end

endmodule : control_flag_fault_gating

/* File: control_flag_fault_gating_assertions.sv */
// Concurrent checks on the ports of the control flag block.
// Assumes the single core clock and the active-low asynchronous reset.
`timescale 1ns/10ps

module control_flag_fault_gating_assertions
  import fault_gating_pkg::*;
(
  input wire logic                           clock_i,
  input wire logic                           rst_n_i,
  input wire logic                           instr_valid_i,
  input wire fault_gating_pkg::instr_class_t instr_class_i,
  input wire logic [1:0]                     cpl_i,
  input wire fault_gating_pkg::cr_sel_t      cr_sel_i,
  input wire logic [31:0]                    wr_data_i,
  input wire logic [2:0]                     dbg_idx_i,
  input wire logic                           task_switch_i,
  input wire logic                           hw_check_i,
  input wire logic                           done_o,
  input wire logic                           fpu_unavailable_fault_o,
  input wire logic                           illegal_op_fault_o,
  input wire logic                           protection_fault_o,
  input wire logic                           protected_mode_o,
  input wire logic                           paging_active_o,
  input wire logic                           root_fetch_nocache_o,
  input wire logic                           root_fetch_wt_o,
  input wire logic                           wide_phys_o,
  input wire logic                           tlb_flush_o,
  input wire logic                           hw_check_exc_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_one_answer: assert property (instr_valid_i |=> $onehot({done_o, fpu_unavailable_fault_o,
    illegal_op_fault_o, protection_fault_o})) else $error("answer count wrong");
  a_quiet_idle: assert property (!instr_valid_i |=> !(done_o || fpu_unavailable_fault_o ||
    illegal_op_fault_o || protection_fault_o)) else $error("answer without request");
  a_sync_no_ud: assert property (instr_valid_i && instr_class_i == IC_FPU_SYNC |=>
    !illegal_op_fault_o && !protection_fault_o) else $error("sync op misfault");
  a_exempt_runs: assert property (instr_valid_i && instr_class_i == IC_VECTOR_EXEMPT |=>
    done_o) else $error("exempt op blocked");
  a_level0_reads: assert property (instr_valid_i && cpl_i == 2'h0 && (instr_class_i ==
    IC_TIMESTAMP || instr_class_i == IC_PERF_READ) |=> !protection_fault_o)
    else $error("level 0 read refused");
  a_paging_pe: assert property (instr_valid_i && instr_class_i == IC_CR_WRITE &&
    cr_sel_i == SEL_SYS && wr_data_i[31] && !wr_data_i[0] && cpl_i == 2'h0 |=>
    protection_fault_o) else $error("paging without protection accepted");
  a_pg_needs_pe: assert property (paging_active_o |-> protected_mode_o)
    else $error("paging active outside protected mode");
  a_root_plain: assert property (root_fetch_nocache_o || root_fetch_wt_o |->
    paging_active_o && !wide_phys_o) else $error("root fetch flags misapplied");
  a_switch_flush: assert property (task_switch_i |=> tlb_flush_o)
    else $error("no flush after task switch");
  a_mce_cause: assert property (hw_check_exc_o |-> $past(hw_check_i))
    else $error("machine check without event");
  a_dbg_plain: assert property (instr_valid_i && instr_class_i == IC_DEBUG_REF &&
    dbg_idx_i != 3'h4 && dbg_idx_i != 3'h5 |=> !illegal_op_fault_o)
    else $error("plain debug ref faulted");
endmodule : control_flag_fault_gating_assertions

bind control_flag_fault_gating control_flag_fault_gating_assertions i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
  .instr_class_i(instr_class_i), .cpl_i(cpl_i), .cr_sel_i(cr_sel_i), .wr_data_i(wr_data_i),
  .dbg_idx_i(dbg_idx_i), .task_switch_i(task_switch_i), .hw_check_i(hw_check_i),
  .done_o(done_o), .fpu_unavailable_fault_o(fpu_unavailable_fault_o),
  .illegal_op_fault_o(illegal_op_fault_o), .protection_fault_o(protection_fault_o),
  .protected_mode_o(protected_mode_o), .paging_active_o(paging_active_o),
  .root_fetch_nocache_o(root_fetch_nocache_o), .root_fetch_wt_o(root_fetch_wt_o),
  .wide_phys_o(wide_phys_o), .tlb_flush_o(tlb_flush_o), .hw_check_exc_o(hw_check_exc_o));

/* File: control_flag_fault_gating_tb.sv */
// Self-checking bench for the control flag block.
// Assumes the checker is bound separately; inputs move 2 ns after each rising edge.
`timescale 1ns/10ps

module control_flag_fault_gating_tb;
  import fault_gating_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [3:0] OK = 4'h8, NM = 4'h4, UD = 4'h2, GP = 4'h1;
  logic         clock_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         instr_valid_i = 1'b0, task_switch_i = 1'b0, hw_check_i = 1'b0;
  instr_class_t instr_class_i = IC_OTHER;
  cr_sel_t      cr_sel_i = SEL_NONE;
  logic [1:0]   cpl_i = 2'h0;
  logic [31:0]  wr_data_i = 32'h0;
  logic [2:0]   dbg_idx_i = 3'h0;
  logic         done_o, fpu_unavailable_fault_o, illegal_op_fault_o, protection_fault_o;
  logic         protected_mode_o, paging_active_o, root_fetch_nocache_o, root_fetch_wt_o;
  logic         v86_ext_o, prot_virq_o, large_page_o, wide_phys_o, ext_state_vector_o;
  logic         tlb_flush_o, keep_global_o, hw_check_exc_o;
  logic [31:0]  rd_data_o;
  logic [2:0]   dbg_index_o;
  int           err_count = 0;
  int           comparisons = 0;

  always #12.5 clock_i = ~clock_i;

  control_flag_fault_gating i_control_flag_fault_gating (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_class_i(instr_class_i), .cpl_i(cpl_i), .cr_sel_i(cr_sel_i), .wr_data_i(wr_data_i),
    .dbg_idx_i(dbg_idx_i), .task_switch_i(task_switch_i), .hw_check_i(hw_check_i),
    .done_o(done_o), .fpu_unavailable_fault_o(fpu_unavailable_fault_o),
    .illegal_op_fault_o(illegal_op_fault_o), .protection_fault_o(protection_fault_o),
    .rd_data_o(rd_data_o), .dbg_index_o(dbg_index_o), .protected_mode_o(protected_mode_o),
    .paging_active_o(paging_active_o), .root_fetch_nocache_o(root_fetch_nocache_o),
    .root_fetch_wt_o(root_fetch_wt_o), .v86_ext_o(v86_ext_o), .prot_virq_o(prot_virq_o),
    .large_page_o(large_page_o), .wide_phys_o(wide_phys_o),
    .ext_state_vector_o(ext_state_vector_o), .tlb_flush_o(tlb_flush_o),
    .keep_global_o(keep_global_o), .hw_check_exc_o(hw_check_exc_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // One request after an idle edge, answered one cycle later; exp is {done, nm, ud, gp}.
  task automatic op(input instr_class_t c, input logic [1:0] p, input cr_sel_t s,
                    input logic [31:0] w, input logic [2:0] d, input logic [3:0] exp);
    @(posedge clock_i);
    #2;
    instr_valid_i = 1'b1;
    instr_class_i = c;
    cpl_i = p;
    cr_sel_i = s;
    wr_data_i = w;
    dbg_idx_i = d;
    @(posedge clock_i);
    #2;
    instr_valid_i = 1'b0;
    check({28'h0, done_o, fpu_unavailable_fault_o, illegal_op_fault_o, protection_fault_o},
          {28'h0, exp});
  endtask : op

  task automatic wr(input cr_sel_t s, input logic [31:0] v);
    op(IC_CR_WRITE, 2'h0, s, v, 3'h0, OK);
  endtask : wr

  task automatic rd(input cr_sel_t s, input logic [31:0] exp);
    op(IC_CR_READ, 2'h0, s, 32'h0, 3'h0, OK);
    check(rd_data_o, exp);
  endtask : rd

  // Event pulses last exactly one cycle, as the block expects.
  task automatic pulse(input bit ts);
    task_switch_i = ts;
    hw_check_i = !ts;
    @(posedge clock_i);
    #2;
    task_switch_i = 1'b0;
    hw_check_i = 1'b0;
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(SEL_SYS, 32'h0);
    rd(SEL_ROOT, 32'h0);
    rd(SEL_EXT, 32'h0);
  endtask : t_reset

  task automatic t_fpu_table();
    logic em, mp, ts;
    wr(SEL_EXT, 32'h0000_0200);
    for (int i = 0; i < 8; i++) begin
      {em, mp, ts} = 3'(i);
      wr(SEL_SYS, {28'h0, ts, em, mp, 1'b0});
      op(IC_FPU, 2'h0, SEL_NONE, 32'h0, 3'h0, (em | ts) ? NM : OK);
      op(IC_FPU_SYNC, 2'h0, SEL_NONE, 32'h0, 3'h0, (mp & ts) ? NM : OK);
      op(IC_PACKED_INT, 2'h0, SEL_NONE, 32'h0, 3'h0, em ? UD : (ts ? NM : OK));
      op(IC_VECTOR, 2'h0, SEL_NONE, 32'h0, 3'h0, em ? UD : (ts ? NM : OK));
      op(IC_VECTOR_EXEMPT, 2'h0, SEL_NONE, 32'h0, 3'h0, OK);
    end
  endtask : t_fpu_table

  task automatic t_task_switch();
    wr(SEL_SYS, 32'h0);
    pulse(1'b1);
    check(32'(tlb_flush_o), 32'h1);
    rd(SEL_SYS, 32'h8);
    op(IC_EXT_SAVE, 2'h0, SEL_NONE, 32'h0, 3'h0, NM);
    op(IC_EXT_LOAD, 2'h0, SEL_NONE, 32'h0, 3'h0, NM);
    op(IC_OTHER, 2'h0, SEL_NONE, 32'h0, 3'h0, OK);
    op(IC_CLEAR_TASK, 2'h0, SEL_NONE, 32'h0, 3'h0, OK);
    rd(SEL_SYS, 32'h0);
    op(IC_FPU, 2'h0, SEL_NONE, 32'h0, 3'h0, OK);
  endtask : t_task_switch

  task automatic t_ext_flags();
    wr(SEL_EXT, 32'h0000_0233);
    check(32'({v86_ext_o, prot_virq_o, large_page_o, wide_phys_o, ext_state_vector_o}),
          32'h1f);
    wr(SEL_EXT, 32'h0);
    check(32'({v86_ext_o, prot_virq_o, large_page_o, wide_phys_o, ext_state_vector_o}),
          32'h0);
    op(IC_VECTOR, 2'h0, SEL_NONE, 32'h0, 3'h0, UD);
    op(IC_VECTOR_EXEMPT, 2'h0, SEL_NONE, 32'h0, 3'h0, OK);
  endtask : t_ext_flags

  task automatic t_privilege();
    wr(SEL_SYS, 32'h1);
    wr(SEL_EXT, 32'h0000_010c);
    op(IC_TIMESTAMP, 2'h3, SEL_NONE, 32'h0, 3'h0, GP);
    op(IC_TIMESTAMP, 2'h0, SEL_NONE, 32'h0, 3'h0, OK);
    op(IC_TIMESTAMP_AUX, 2'h3, SEL_NONE, 32'h0, 3'h0, GP);
    op(IC_PERF_READ, 2'h3, SEL_NONE, 32'h0, 3'h0, OK);
    op(IC_DEBUG_REF, 2'h0, SEL_NONE, 32'h0, 3'h4, UD);
    op(IC_CR_READ, 2'h3, SEL_SYS, 32'h0, 3'h0, GP);
    op(IC_CR_WRITE, 2'h1, SEL_EXT, 32'h0, 3'h0, GP);
    wr(SEL_EXT, 32'h0);
    op(IC_TIMESTAMP, 2'h3, SEL_NONE, 32'h0, 3'h0, OK);
    op(IC_PERF_READ, 2'h2, SEL_NONE, 32'h0, 3'h0, GP);
    op(IC_DEBUG_REF, 2'h3, SEL_NONE, 32'h0, 3'h5, OK);
    check(32'(dbg_index_o), 32'h7);
  endtask : t_privilege

  task automatic t_paging();
    wr(SEL_SYS, 32'h0);
    op(IC_CR_WRITE, 2'h0, SEL_SYS, 32'h8000_0000, 3'h0, GP);
    rd(SEL_SYS, 32'h0);
    wr(SEL_SYS, 32'h8000_0001);
    check(32'({protected_mode_o, paging_active_o}), 32'h3);
    wr(SEL_ROOT, 32'hffff_ffff);
    check(32'({tlb_flush_o, root_fetch_nocache_o, root_fetch_wt_o}), 32'h7);
    rd(SEL_ROOT, 32'hffff_f018);
    wr(SEL_EXT, 32'h0000_0020);
    check(32'({root_fetch_nocache_o, root_fetch_wt_o}), 32'h0);
    wr(SEL_EXT, 32'h0000_0080);
    @(posedge clock_i);
    #2;
    check(32'(keep_global_o), 32'h1);
    pulse(1'b0);
    check(32'(hw_check_exc_o), 32'h0);
    wr(SEL_EXT, 32'h0000_0040);
    pulse(1'b0);
    check(32'(hw_check_exc_o), 32'h1);
  endtask : t_paging

  task automatic t_masks();
    wr(SEL_SYS, 32'hffff_ffff);
    rd(SEL_SYS, 32'h8000_000f);
    wr(SEL_EXT, 32'hffff_ffff);
    rd(SEL_EXT, 32'h0002_03ff);
    op(IC_CR_WRITE, 2'h0, SEL_NONE, 32'h0, 3'h0, UD);
  endtask : t_masks

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    #2;
    rst_n_i = 1'b1;
    t_reset();
    t_fpu_table();
    t_task_switch();
    t_ext_flags();
    t_privilege();
    t_paging();
    t_masks();
    conclude();
  end

  // A hang is cut short well past the length of the whole sequence.
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    conclude();
  end
endmodule : control_flag_fault_gating_tb

/* File: fault_classifier.sv */
// Combinational fault decision for one instruction.
// Assumes flags are the committed register values of the enclosing block.
`timescale 1ns/10ps

module fault_classifier
  import fault_gating_pkg::*;
#(
  parameter bit AUX_TS_PRESENT = 1'b1
) (
  input  wire fault_gating_pkg::instr_class_t cls_i,
  input  wire logic [1:0]                     cpl_i,
  input  wire fault_gating_pkg::cr_sel_t      sel_i,
  input  wire logic [2:0]                     dbg_idx_i,
  input  wire logic [31:0]                    wr_data_i,
  input  wire logic [31:0]                    sys_i,
  input  wire logic [31:0]                    ext_i,
  output logic                                ud_o,
  output logic                                nm_o,
  output logic                                gp_o
);

  function automatic logic low_priv(input logic pe, input logic [1:0] cpl);
    low_priv = pe && (cpl != 2'h0);
  endfunction : low_priv

  logic em;
  logic ts;
  logic pe;

  assign em = sys_i[FPU_ABSENT_BIT];
  assign ts = sys_i[TASK_SW_BIT];
  assign pe = sys_i[PROT_EN_BIT];

  always_comb begin
    ud_o = 1'b0;
    nm_o = 1'b0;
    gp_o = 1'b0;
    case (cls_i)
      IC_FPU, IC_EXT_SAVE, IC_EXT_LOAD: begin
        nm_o = em || ts;
      end
      IC_FPU_SYNC: begin
        nm_o = sys_i[MON_COPROC_BIT] && ts;
      end
      IC_PACKED_INT: begin
        ud_o = em;
        nm_o = !em && ts;
      end
      IC_VECTOR: begin
        ud_o = em || !ext_i[OS_EXT_BIT];
        nm_o = !ud_o && ts;
      end
      IC_TIMESTAMP, IC_TIMESTAMP_AUX: begin
        ud_o = (cls_i == IC_TIMESTAMP_AUX) && !AUX_TS_PRESENT;
        gp_o = !ud_o && ext_i[CNT_LOCK_BIT] && (cpl_i != 2'h0);
      end
      IC_PERF_READ: begin
        gp_o = !ext_i[PERF_OPEN_BIT] && (cpl_i != 2'h0);
      end
      IC_DEBUG_REF: begin
        ud_o = ext_i[DBG_TRAP_BIT] &&
               (dbg_idx_i == DBG_REG_FOUR || dbg_idx_i == DBG_REG_FIVE);
      end
      IC_CR_READ: begin
        ud_o = (sel_i == SEL_NONE);
        gp_o = !ud_o && low_priv(pe, cpl_i);
      end
      IC_CR_WRITE: begin
        ud_o = (sel_i == SEL_NONE);
        gp_o = !ud_o && (low_priv(pe, cpl_i) ||
               (sel_i == SEL_SYS && wr_data_i[PAGING_ON_BIT] &&
                !wr_data_i[PROT_EN_BIT]));
      end
      IC_CLEAR_TASK: begin
        gp_o = low_priv(pe, cpl_i);
      end
      default: begin
        ud_o = 1'b0;
      end
    endcase
  end

endmodule : fault_classifier

/* File: fault_gating_pkg.sv */
// Constants, field positions and types shared by the control flag block.
// Assumes a single core clock and that every request comes from same-clock logic.
//
// Overview of operation
// - Floating-point op faults unavailable if fpu-absent or task-switched set.
// - Sync op faults unavailable only when monitor and task-switched flags both set.
// - Task switch sets the task-switched flag and requests a translation flush; no state is saved here.
// - Clear-task-flag op resets the task-switched flag.
// - Packed-integer ops fault illegal-opcode while fpu-absent is set.
// - Vector ops fault illegal-opcode while fpu-absent is set; nine exempt ops pass.
// - Protection enable selects protected mode; paging needs protection and paging on.
// - Root-table cache flags apply only under plain 32-bit paging.
// - V86 extensions flag enables redirection extensions.
// - Protected virtual interrupt flag enables virtual interrupt support.
// - Counter-read lock limits timestamp reads to level 0.
// - Debug alias trap faults references to debug registers four and five.
// - Large page enable allows 4-MByte pages under 32-bit paging.
// - Wide physical address flag allows addresses beyond 32 bits.
// - Machine-check exception delivered only while its enable is set.
// - Global page keep preserves global translations across flushes.
// - Performance counter read open at any level only while flag set.
// - Os-extended-state set: extended save includes vector state, vectors run.
// - Os-extended-state clear: non-exempt vector ops fault illegal-opcode.
// - Setting paging on with protection off raises protection fault.
// - Control register access in protected mode only at level 0.

package fault_gating_pkg;

  localparam int unsigned DATA_W = 32;

  // System control flag positions.
  localparam int unsigned PROT_EN_BIT    = 0;
  localparam int unsigned MON_COPROC_BIT = 1;
  localparam int unsigned FPU_ABSENT_BIT = 2;
  localparam int unsigned TASK_SW_BIT    = 3;
  localparam int unsigned PAGING_ON_BIT  = 31;

  // Paging root pointer positions.
  localparam int unsigned ROOT_WT_BIT = 3;
  localparam int unsigned ROOT_NC_BIT = 4;

  // Extension control flag positions.
  localparam int unsigned V86_EXT_BIT    = 0;
  localparam int unsigned PROT_VIRQ_BIT  = 1;
  localparam int unsigned CNT_LOCK_BIT   = 2;
  localparam int unsigned DBG_TRAP_BIT   = 3;
  localparam int unsigned LARGE_PAGE_BIT = 4;
  localparam int unsigned WIDE_PHYS_BIT  = 5;
  localparam int unsigned HW_CHECK_BIT   = 6;
  localparam int unsigned GLOBAL_KEEP_BIT = 7;
  localparam int unsigned PERF_OPEN_BIT  = 8;
  localparam int unsigned OS_EXT_BIT     = 9;
  localparam int unsigned CTX_ID_BIT     = 17;

  // Writable bits; the rest keep their previous value.
  localparam logic [31:0] SYS_CTL_WMASK  = 32'h8000_000f;
  localparam logic [31:0] ROOT_PTR_WMASK = 32'hffff_f018;
  localparam logic [31:0] EXT_CTL_WMASK  = 32'h0002_03ff;

  localparam logic [31:0] SYS_CTL_RESET  = 32'h0000_0000;
  localparam logic [31:0] ROOT_PTR_RESET = 32'h0000_0000;
  localparam logic [31:0] EXT_CTL_RESET  = 32'h0000_0000;

  localparam logic [2:0] DBG_REG_FOUR  = 3'h4;
  localparam logic [2:0] DBG_REG_FIVE  = 3'h5;
  localparam logic [2:0] DBG_ALIAS_OFS = 3'h2;

  typedef enum logic [1:0] {SEL_SYS, SEL_ROOT, SEL_EXT, SEL_NONE} cr_sel_t;

  typedef enum logic [3:0] {
    IC_OTHER, IC_FPU, IC_FPU_SYNC, IC_PACKED_INT, IC_VECTOR, IC_VECTOR_EXEMPT,
    IC_TIMESTAMP, IC_TIMESTAMP_AUX, IC_PERF_READ, IC_DEBUG_REF, IC_CR_READ,
    IC_CR_WRITE, IC_CLEAR_TASK, IC_EXT_SAVE, IC_EXT_LOAD
  } instr_class_t;

endpackage : fault_gating_pkg
